// ==== bench/coil_model.sv ====
`timescale 1ns/1ps
module coil_model
  import vpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire stat_s status,
  input wire logic [7:0] blank_cycles,
  output logic [7:0] coil_current
);
  logic [7:0] on_cnt;
  always @(posedge clk) begin
    if (rst) begin
      on_cnt <= 8'h00;
      coil_current <= 8'h5a;
    end else begin
      on_cnt <= status.pwm_on ? on_cnt + {7'h00, on_cnt != 8'hff} : 8'h00;
      if (!status.pwm_on) coil_current <= ~coil_current;
      else if (on_cnt < blank_cycles) coil_current <= 8'hff;
      else coil_current <= {1'b0, status.scale[7:1]};
    end
  end
endmodule : coil_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_top;
  import vpwm_pkg::*;
  logic clk, rst, standstill;
  cfg_s cfg;
  logic [7:0] run_current_setting, coil_current, s0, blank_len;
  logic [22:0] velocity, chopper_switch_velocity;
  stat_s status;
  int failures, checked, n;
  voltage_pwm_amplitude_regulator voltage_pwm_amplitude_regulator_inst (
    .clk(clk), .rst(rst), .cfg(cfg), .run_current_setting(run_current_setting),
    .coil_current(coil_current), .velocity(velocity), .standstill(standstill),
    .chopper_switch_velocity(chopper_switch_velocity), .status(status));
  coil_model coil_model_inst (.clk(clk), .rst(rst), .status(status),
    .blank_cycles(blank_len), .coil_current(coil_current));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cy(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cy
  task automatic rise(output int c);
    c = 0;
    while (status.pwm_on !== 1'b0 && c < 3000) begin cy(1); c++; end
    while (status.pwm_on !== 1'b1 && c < 3000) begin cy(1); c++; end
  endtask : rise
  task automatic t_fixed;
    logic [10:0] hp [4] = '{half_period_f0, half_period_f1, half_period_f2,
      half_period_f3};
    cfg = '{1'b0, 4'h1, 8'h55, 2'h0, 2'h0};
    for (int i = 0; i < 4; i++) begin
      cfg.pwm_frequency_select = 2'(i);
      rise(n);
      rise(n);
      `CK("period", 32'(hp[i]) * 2, n)
    end
    `CK("scale", 8'h55, status.scale)
    `CK("peak", 8'((16'(8'h55) * 16'(sine_peak)) >> 8), status.peak)
  endtask : t_fixed
  task automatic t_auto;
    cfg = '{1'b0, grad_off, 8'h55, 2'h3, 2'h1};
    cy(3);
    `CK("off", 1'b0, status.voltage_mode)
    cfg = '{1'b1, 4'hf, 8'h55, 2'h3, 2'h1};
    cy(2000);
    `CK("early", 1'b0, status.scale_stable)
    `CK("idle", 1'b0, status.voltage_mode)
    standstill = 1'b1;
    for (n = 0; n < 60000 && status.scale_stable !== 1'b1; n++) cy(1);
    `CK("stable", 1'b1, status.scale_stable)
    `CK("reg", 1'b1, status.scale inside {[8'h79:8'h87]})
  endtask : t_auto
  task automatic t_gain;
    s0 = status.scale;
    run_current_setting = 8'h50;
    cfg.regulation_gradient = 4'h1;
    cfg.blank_time_select = 2'h2;
    blank_len = blank_t2 - 8'h01;
    cy(1230);
    `CK("slow", 1'b1, status.scale > s0 && status.scale < s0 + 8'h10)
    cfg.regulation_gradient = 4'hf;
    cy(1230);
    `CK("fast", 1'b1, status.scale inside {[8'h99:8'ha7]})
  endtask : t_gain
  task automatic t_vel;
    standstill = 1'b0;
    velocity = 23'h000064;
    cy(3);
    `CK("hi", 1'b0, status.voltage_mode)
    velocity = 23'h00000a;
    cy(1);
    `CK("reentry", 8'h55, status.scale)
    `CK("lo", 1'b1, status.voltage_mode)
  endtask : t_vel
  task automatic t_collapse;
    run_current_setting = 8'h00;
    cfg.blank_time_select = 2'h3;
    blank_len = blank_t3 - 8'h01;
    cy(1640);
    `CK("floor", 8'h00, status.scale)
    standstill = 1'b1;
    run_current_setting = 8'h40;
    cy(2460);
    `CK("recover", 1'b1, status.scale inside {[8'h79:8'h87]})
  endtask : t_collapse
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    rst = 1'b1;
    cfg = '0;
    standstill = 1'b0;
    run_current_setting = 8'h40;
    velocity = '0;
    chopper_switch_velocity = 23'h000032;
    blank_len = blank_t1 - 8'h01;
    failures = 0;
    checked = 0;
    cy(4);
    rst = 1'b0;
    t_fixed;
    t_auto;
    t_gain;
    t_vel;
    t_collapse;
    tally_and_finish;
  end
  initial begin
    #450000;
    failures++;
    tally_and_finish;
  end
endmodule : tb_top

// ==== bench/vpwm_properties.sv ====
`timescale 1ns/1ps
module vpwm_properties
  import vpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cfg_s cfg,
  input wire logic [7:0] run_current_setting,
  input wire logic [7:0] coil_current,
  input wire logic [22:0] velocity,
  input wire logic [22:0] chopper_switch_velocity,
  input wire logic standstill,
  input wire stat_s status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_off;
    cfg.regulation_gradient == grad_off |-> ##[1:2] !status.voltage_mode;
  endproperty
  a_off: assert property (p_off) else $error("on at gain 0");
  property p_vel;
    velocity >= chopper_switch_velocity |-> ##[1:2] !status.voltage_mode;
  endproperty
  a_vel: assert property (p_vel) else $error("on above");
  property p_start;
    $rose(status.scale_stable) && cfg.auto_scale |-> $past(standstill);
  endproperty
  a_start: assert property (p_start) else $error("moving");
  property p_peak;
    1'b1 |=> status.peak == 8'((16'($past(status.scale)) * 16'(sine_peak)) >> 8);
  endproperty
  a_peak: assert property (p_peak) else $error("peak");
  property p_fixed;
    (!cfg.auto_scale && status.voltage_mode) [*4]
      |-> status.scale == cfg.user_amplitude;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed");
  property p_once;
    cfg.auto_scale && status.voltage_mode && $past(status.voltage_mode)
      && status.scale != $past(status.scale) |=> $stable(status.scale) [*8];
  endproperty
  a_once: assert property (p_once) else $error("twice");
  property p_pwm;
    !status.voltage_mode |-> !status.pwm_on;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm idle");
  property p_back;
    cfg.auto_scale && $past(velocity >= chopper_switch_velocity)
      && velocity < chopper_switch_velocity && $past(status.scale_stable)
      |-> ##[1:2] status.scale == cfg.user_amplitude;
  endproperty
  a_back: assert property (p_back) else $error("reentry");
endmodule : vpwm_properties
bind voltage_pwm_amplitude_regulator vpwm_properties vpwm_properties_inst (
  .clk(clk), .rst(rst), .cfg(cfg), .run_current_setting(run_current_setting),
  .coil_current(coil_current), .velocity(velocity), .standstill(standstill),
  .chopper_switch_velocity(chopper_switch_velocity), .status(status));

// ==== hw/period_timer.sv ====
`timescale 1ns/1ps
module period_timer
  import vpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] sel,
  input wire logic [1:0] blank_sel,
  output logic pwm_on,
  output logic period_end,
  output logic sample_ok
);
  logic [10:0] cnt_reg, cnt_next;
  logic on_reg, on_next;
  logic end_reg, end_next;
  logic ok_reg, ok_next;
  logic [10:0] half;
  logic [7:0] blank;

  assign pwm_on = on_reg;
  assign period_end = end_reg;
  assign sample_ok = ok_reg;

  always_comb begin
    case (sel)
      freq_code_0: half = half_period_f0;
      freq_code_1: half = half_period_f1;
      freq_code_2: half = half_period_f2;
      default: half = half_period_f3;
    endcase
    case (blank_sel)
      2'h0: blank = blank_t0;
      2'h1: blank = blank_t1;
      2'h2: blank = blank_t2;
      default: blank = blank_t3;
    endcase
  end

  always_comb begin
    cnt_next = cnt_reg + 11'h001;
    on_next = on_reg;
    end_next = 1'b0;
    if (cnt_reg >= half - 11'h001) begin
      cnt_next = 11'h000;
      on_next = ~on_reg;
      end_next = ~on_reg;
    end
    ok_next = on_reg && (cnt_reg >= {3'h0, blank});
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 11'h000;
      on_reg <= 1'b0;
      end_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      on_reg <= on_next;
      end_reg <= end_next;
      ok_reg <= ok_next;
    end
  end
endmodule : period_timer

// ==== hw/voltage_pwm_amplitude_regulator.sv ====
`timescale 1ns/1ps
module voltage_pwm_amplitude_regulator
  import vpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cfg_s cfg,
  input wire logic [7:0] run_current_setting,
  input wire logic [7:0] coil_current,
  input wire logic [22:0] velocity,
  input wire logic [22:0] chopper_switch_velocity,
  input wire logic standstill,
  output stat_s status
);
  logic pwm_on, period_end, sample_ok;
  reg_state_e state_reg, state_next;
  logic [7:0] scale_reg, scale_next;
  logic [7:0] peak_reg, peak_next;
  logic [7:0] meas_reg, meas_next;
  logic got_reg, got_next;
  logic [7:0] still_reg, still_next;
  logic vmode_reg, vmode_next;
  logic on_out_reg, on_out_next;
  logic stable_reg, stable_next;
  logic enabled, below;
  logic signed [13:0] err, step, sum;
  logic [15:0] prod;
  logic [7:0] clamped;

  period_timer u_timer (
    .clk(clk),
    .rst(rst),
    .sel(cfg.pwm_frequency_select),
    .blank_sel(cfg.blank_time_select),
    .pwm_on(pwm_on),
    .period_end(period_end),
    .sample_ok(sample_ok)
  );

  assign enabled = cfg.regulation_gradient != grad_off;
  assign below = velocity < chopper_switch_velocity;

  always_comb begin
    err = $signed({6'h00, run_current_setting}) -
      $signed({6'h00, meas_reg});
    step = err * $signed({10'h000, cfg.regulation_gradient});
    sum = $signed({6'h00, scale_reg}) + (step >>> 3);
    prod = scale_reg * sine_peak;
    if (sum < 0) begin
      clamped = 8'h00;
    end else if (sum > $signed({6'h00, scale_max})) begin
      clamped = scale_max;
    end else begin
      clamped = sum[7:0];
    end
  end

  always_comb begin
    meas_next = meas_reg;
    got_next = got_reg;
    if (period_end) begin
      got_next = 1'b0;
    end
    if (sample_ok && vmode_reg) begin
      meas_next = coil_current;
      got_next = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    scale_next = scale_reg;
    still_next = still_reg;
    stable_next = stable_reg;
    if (period_end && still_reg != startup_periods) begin
      still_next = standstill ? still_reg + 8'h01 : 8'h00;
    end
    if (!standstill) begin
      still_next = 8'h00;
    end
    case (state_reg)
      st_off: begin
        stable_next = 1'b0;
        if (enabled && below) begin
          if (!cfg.auto_scale) begin
            state_next = st_run;
          end else if (standstill) begin
            state_next = st_startup;
            scale_next = scale_reset;
          end
        end
      end
      st_startup: begin
        if (period_end && got_reg) begin
          scale_next = clamped;
        end
        if (still_reg == startup_periods) begin
          state_next = st_run;
          stable_next = 1'b1;
        end
      end
      st_run: begin
        if (!cfg.auto_scale) begin
          scale_next = cfg.user_amplitude;
          stable_next = 1'b1;
        end else if (standstill && scale_reg < collapse_floor) begin
          state_next = st_startup;
          still_next = 8'h00;
        end else if (period_end && got_reg) begin
          scale_next = clamped;
        end
        if (!below) begin
          state_next = st_other;
        end
      end
      st_other: begin
        if (below) begin
          state_next = st_run;
          scale_next = cfg.user_amplitude;
        end
      end
      default: state_next = st_off;
    endcase
    if (!enabled) begin
      state_next = st_off;
    end
  end

  always_comb begin
    vmode_next = enabled && below &&
      (state_next == st_run || state_next == st_startup);
    on_out_next = vmode_next && pwm_on;
    peak_next = prod[15:8];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meas_reg <= 8'h00;
      got_reg <= 1'b0;
    end else begin
      meas_reg <= meas_next;
      got_reg <= got_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= st_off;
      scale_reg <= scale_reset;
      still_reg <= 8'h00;
      stable_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      scale_reg <= scale_next;
      still_reg <= still_next;
      stable_reg <= stable_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      peak_reg <= 8'h00;
      vmode_reg <= 1'b0;
      on_out_reg <= 1'b0;
    end else begin
      peak_reg <= peak_next;
      vmode_reg <= vmode_next;
      on_out_reg <= on_out_next;
    end
  end

  assign status = '{scale: scale_reg, peak: peak_reg, voltage_mode: vmode_reg,
    pwm_on: on_out_reg, scale_stable: stable_reg};
endmodule : voltage_pwm_amplitude_regulator

// ==== hw/vpwm_pkg.sv ====
package vpwm_pkg;
  localparam int unsigned clk_mhz = 200;
  localparam logic [10:0] half_period_f0 = 11'h200;
  localparam logic [10:0] half_period_f1 = 11'h156;
  localparam logic [10:0] half_period_f2 = 11'h100;
  localparam logic [10:0] half_period_f3 = 11'h0cd;
  localparam logic [1:0] freq_code_0 = 2'h0;
  localparam logic [1:0] freq_code_1 = 2'h1;
  localparam logic [1:0] freq_code_2 = 2'h2;
  localparam logic [7:0] blank_t0 = 8'h10;
  localparam logic [7:0] blank_t1 = 8'h18;
  localparam logic [7:0] blank_t2 = 8'h24;
  localparam logic [7:0] blank_t3 = 8'h36;
  localparam logic [7:0] sine_peak = 8'hf8;
  localparam logic [7:0] scale_max = 8'hff;
  localparam logic [7:0] scale_reset = 8'h00;
  localparam logic [3:0] grad_off = 4'h0;
  localparam logic [7:0] startup_periods = 8'h80;
  localparam logic [7:0] collapse_floor = 8'h04;

  typedef enum logic [1:0] {
    st_off,
    st_startup,
    st_run,
    st_other
  } reg_state_e;

  typedef struct packed {
    logic auto_scale;
    logic [3:0] regulation_gradient;
    logic [7:0] user_amplitude;
    logic [1:0] pwm_frequency_select;
    logic [1:0] blank_time_select;
  } cfg_s;

  typedef struct packed {
    logic [7:0] scale;
    logic [7:0] peak;
    logic voltage_mode;
    logic pwm_on;
    logic scale_stable;
  } stat_s;
endpackage : vpwm_pkg
